// [hdl/audio_tx_pkg.sv]
// Shared register map, field layouts and codes for the stereo audio transmitter
package audio_tx_pkg;

	localparam logic [31:0] CONFIG_ADDR  = 32'he000_0000;
	localparam logic [31:0] STATUS_ADDR  = 32'he000_0004;
	localparam logic [31:0] PENDING_ADDR = 32'he000_0008;
	localparam logic [31:0] ENABLE_ADDR  = 32'he000_000c;
	localparam logic [31:0] LEFT_ADDR    = 32'he000_0010;
	localparam logic [31:0] RIGHT_ADDR   = 32'he000_0014;

	localparam logic [31:0] CONFIG_RESET = 32'h0000_0102;
	localparam logic [31:0] CONFIG_WMASK = 32'hc000_1f7f;

	localparam int          BUSY_BIT     = 28;
	localparam int          CODE_LSB     = 24;
	localparam int          EVT_ERROR    = 8;
	localparam int          EVT_W        = 9;
	localparam logic [3:0]  ERR_RESET    = 4'hf;
	localparam logic [3:0]  ERR_LEFT_FULL  = 4'h1;
	localparam logic [3:0]  ERR_RIGHT_FULL = 4'h2;

	localparam logic [1:0]  AXI_OKAY     = 2'h0;
	localparam logic [1:0]  AXI_SLVERR   = 2'h2;

	localparam logic [2:0]  WIDTH_8      = 3'h0;
	localparam logic [2:0]  WIDTH_16     = 3'h1;
	localparam logic [2:0]  WIDTH_18     = 3'h2;
	localparam logic [2:0]  WIDTH_24     = 3'h3;
	localparam logic [2:0]  WIDTH_32     = 3'h4;
	localparam logic [6:0]  BITS_8       = 7'h08;
	localparam logic [6:0]  BITS_16      = 7'h10;
	localparam logic [6:0]  BITS_18      = 7'h12;
	localparam logic [6:0]  BITS_24      = 7'h18;
	localparam logic [6:0]  BITS_32      = 7'h20;

	typedef enum logic [1:0] {
		FMT_I2S     = 2'h0,
		FMT_LEFT    = 2'h1,
		FMT_RIGHT   = 2'h2,
		FMT_I2S_ALT = 2'h3
	} fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_RUN  = 2'h2
	} state_t;

	typedef struct packed {
		logic        enable;
		logic        flush;
		logic [16:0] rsvdHigh;
		fmt_t        format;
		logic [2:0]  width;
		logic        rsvdLow;
		logic        dma;
		logic        mono;
		logic        fixedRatio;
		logic        wordSelectPolarity;
		logic        bitOrderSel;
		logic        mute;
		logic        hold;
	} cfg_t;

	typedef struct packed {
		logic        valid;
		logic        eot;
		logic        empty;
		logic [31:0] data;
	} dma_src_t;

endpackage : audio_tx_pkg

// [hdl/sample_fifo.sv]
// Per-channel sample FIFO with registered read data
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic                           flush,
	input  wire logic                           push,
	input  wire logic [WIDTH-1:0]               pushData,
	input  wire logic                           pop,
	output logic      [WIDTH-1:0]               popData,
	output logic      [$clog2(DEPTH+1)-1:0]     count,
	output logic                                full,
	output logic                                empty
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [$clog2(DEPTH+1)-1:0] FULL_COUNT = ($clog2(DEPTH+1))'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic             doPush;
	logic             doPop;

	assign doPush = push && !full;
	assign doPop  = pop && !empty;
	assign full   = (count == FULL_COUNT);
	assign empty  = (count == '0);

	always_ff @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr_q] <= pushData;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			popData <= '0;
		else if (doPop)
			popData <= mem[rdPtr_q];
	end

	// Flush beats a simultaneous push so nothing stale survives
	always_ff @(posedge clk)
	begin
		if (reset || flush)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count   <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
			if (doPush && !doPop)
				count <= count + 1'b1;
			else if (doPop && !doPush)
				count <= count - 1'b1;
		end
	end
endmodule : sample_fifo

// [hdl/stereo_audio_serial_transmitter.sv]
// Stereo audio serial transmitter with AXI4-Lite registers and DMA sample inputs
// Function
// - Clearing enable finishes the current frame; DMA mode discards pending samples.
// - Flush bit while disabled empties FIFOs; software waits for drained flag.
// - Format 0 and 3 give I2S framing, 1 left-justified, 2 right-justified.
// - Width codes 0..4 select 8,16,18,24,32 bits; reset selects 16.
// - Mono takes left samples only and sends each on both slots.
// - Bit clock is 16, 32 or 64 per frame by width, or always 64.
// - Word-select polarity maps WS level to channel; bit order picks MSB/LSB first.
// - Mute keeps consuming samples but sends zeros; mute resets set.
// - Hold sends zero frames with clock running, losing and skipping no sample.
// - A descriptor change in the feeding socket flushes all FIFOs.
// - Busy shows while transmitting; software polls it before reconfiguring.
// - Fault cause keeps only the first error while error is set; resets all ones.
// - Error flag is sticky, cleared only by software writing one.
// - In DMA mode underrun is high while no sample but socket not empty.
// - Hold-effective flag is high exactly while hold acts on the output.
// - Half-empty and room flags per channel follow the FIFO, reset to one.
// - Drained flag: FIFO and shifter empty after a start, register or DMA form.
// - Each request bit sets on its status rising edge and clears by writing one.
// - Mask bits forward requests to the interrupt but never affect setting.
// - Outside DMA mode a sample port write appends one sample, or raises error when full.
// - Sample ports are write-only; FIFO depth is a design parameter.
`timescale 1ns/1ps
module stereo_audio_serial_transmitter #(
	parameter int FIFO_DEPTH = 16,
	parameter int SCK_HALF   = 4
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [31:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [31:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire audio_tx_pkg::dma_src_t leftDma,
	input  wire audio_tx_pkg::dma_src_t rightDma,
	input  wire logic                  descModified,
	output logic                       leftDmaReady,
	output logic                       rightDmaReady,
	output logic                       sck,
	output logic                       ws,
	output logic                       sd,
	output logic                       irq
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int HW = $clog2(SCK_HALF + 1);
	localparam logic [HW-1:0] HALF_LAST = HW'(SCK_HALF - 1);
	localparam logic [CW-1:0] DEPTH_C   = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] HALF_C    = CW'(FIFO_DEPTH / 2);

	audio_tx_pkg::cfg_t   cfg_q;
	audio_tx_pkg::state_t state_q;
	audio_tx_pkg::dma_src_t dmaSrc [2];
	logic [31:0] awAddr_q, wData_q, wMask_q;
	logic        awHeld_q, wHeld_q, doWrite;
	logic [31:0] rdWord;
	logic [1:0]  rdResp;
	logic        enableSync_q, flushAll, flushActive, run, fall, frameStart, stopEvt;
	logic [5:0]  pos_q, posNext, wsPos;
	logic [6:0]  slotBits, sampleBits, sIdx;
	logic [HW-1:0] halfCnt_q;
	logic [1:0]  push, pop, popPend_q, holdValid_q, consume, full, empty, regWr;
	logic [1:0]  half_q, room_q, drained_q, eotSeen_q, dmaReady_q;
	logic [31:0] pushData [2];
	logic [31:0] popData [2];
	logic [31:0] hold_q [2];
	logic [31:0] cur_q [2];
	logic [CW-1:0] count [2];
	logic        curZero_q, pausedEff_q, noData_q, started_q, ready, take, zeroN;
	logic [31:0] selL, selR;
	logic        error_q, errSet, errClr;
	logic [3:0]  errCode_q, errCause;
	localparam int EVT_W_L = audio_tx_pkg::EVT_W;
	logic [EVT_W_L-1:0] status, statusPrev_q, rise, irqPend_q, irqEn_q;

	function automatic logic [6:0] widthBits(input logic [2:0] code);
		case (code)
			audio_tx_pkg::WIDTH_8:  widthBits = audio_tx_pkg::BITS_8;
			audio_tx_pkg::WIDTH_18: widthBits = audio_tx_pkg::BITS_18;
			audio_tx_pkg::WIDTH_24: widthBits = audio_tx_pkg::BITS_24;
			audio_tx_pkg::WIDTH_32: widthBits = audio_tx_pkg::BITS_32;
			default:                widthBits = audio_tx_pkg::BITS_16;
		endcase
	endfunction : widthBits

	// Upper bits beyond the width are ignored, so the sample sits LSB aligned
	function automatic logic bitAt(input logic [31:0] smp, input logic [6:0] s,
		input logic [6:0] slot, input logic [6:0] nb, input logic rj, input logic lsb);
		logic [6:0] off;
		logic [6:0] i;
		logic [6:0] idx;
		off = rj ? slot - nb : 7'h00;
		i = s - off;
		idx = lsb ? i : nb - 7'h01 - i;
		bitAt = (s >= off) && (i < nb) && smp[idx[4:0]];
	endfunction : bitAt

	assign dmaSrc[0] = leftDma;
	assign dmaSrc[1] = rightDma;

	// AXI4-Lite write: address and data taken in either order, response after both
	assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awHeld_q      <= 1'b0;
			wHeld_q       <= 1'b0;
			awAddr_q      <= '0;
			wData_q       <= '0;
			wMask_q       <= '0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= audio_tx_pkg::AXI_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q      <= 1'b1;
				awAddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q      <= 1'b1;
				wData_q      <= s_axi_wdata;
				wMask_q      <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_q > audio_tx_pkg::RIGHT_ADDR
					|| awAddr_q < audio_tx_pkg::CONFIG_ADDR || awAddr_q[1:0] != 2'h0)
					? audio_tx_pkg::AXI_SLVERR : audio_tx_pkg::AXI_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb
	begin
		rdResp = audio_tx_pkg::AXI_OKAY;
		rdWord = '0;
		unique case (s_axi_araddr)
			audio_tx_pkg::CONFIG_ADDR:  rdWord = cfg_q;
			audio_tx_pkg::STATUS_ADDR:
			begin
				rdWord = 32'(status);
				rdWord[audio_tx_pkg::BUSY_BIT] = run;
				rdWord[audio_tx_pkg::CODE_LSB +: 4] = errCode_q;
			end
			audio_tx_pkg::PENDING_ADDR: rdWord = 32'(irqPend_q);
			audio_tx_pkg::ENABLE_ADDR:  rdWord = 32'(irqEn_q);
			audio_tx_pkg::LEFT_ADDR, audio_tx_pkg::RIGHT_ADDR: rdWord = '0;
			default:                    rdResp = audio_tx_pkg::AXI_SLVERR;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= audio_tx_pkg::AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdWord;
			s_axi_rresp   <= rdResp;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cfg_q   <= audio_tx_pkg::CONFIG_RESET;
			irqEn_q <= '0;
		end
		else if (doWrite && awAddr_q == audio_tx_pkg::CONFIG_ADDR)
			cfg_q <= (cfg_q & ~(wMask_q & audio_tx_pkg::CONFIG_WMASK))
				| (wData_q & wMask_q & audio_tx_pkg::CONFIG_WMASK);
		else if (doWrite && awAddr_q == audio_tx_pkg::ENABLE_ADDR)
			irqEn_q <= (irqEn_q & ~wMask_q[EVT_W_L-1:0]) | (wData_q[EVT_W_L-1:0]
				& wMask_q[EVT_W_L-1:0]);
	end

	// Software must not change other fields with enable, so one stage suffices here
	always_ff @(posedge clk)
	begin
		if (reset)
			enableSync_q <= 1'b0;
		else
			enableSync_q <= cfg_q.enable;
	end

	assign flushActive = cfg_q.flush && !cfg_q.enable;
	assign stopEvt     = frameStart && !enableSync_q;
	assign flushAll    = flushActive || descModified || (stopEvt && cfg_q.dma);
	assign regWr[0]    = doWrite && awAddr_q == audio_tx_pkg::LEFT_ADDR && !cfg_q.dma;
	assign regWr[1]    = doWrite && awAddr_q == audio_tx_pkg::RIGHT_ADDR && !cfg_q.dma;
	assign ready       = holdValid_q[0] && (cfg_q.mono || holdValid_q[1]);
	assign take        = frameStart && enableSync_q && !cfg_q.hold && ready;
	assign consume[0]  = take;
	assign consume[1]  = take && !cfg_q.mono;
	assign leftDmaReady  = dmaReady_q[0];
	assign rightDmaReady = dmaReady_q[1];

	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		assign push[c] = cfg_q.dma ? (dmaSrc[c].valid && dmaReady_q[c] && !full[c])
			: (regWr[c] && !full[c]);
		assign pushData[c] = cfg_q.dma ? dmaSrc[c].data : wData_q;
		assign pop[c] = (c == 0 || !cfg_q.mono) && !holdValid_q[c] && !popPend_q[c]
			&& !empty[c] && !flushAll;

		sample_fifo #(
			.WIDTH (32),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.clk      (clk),
			.reset    (reset),
			.flush    (flushAll),
			.push     (push[c]),
			.pushData (pushData[c]),
			.pop      (pop[c]),
			.popData  (popData[c]),
			.count    (count[c]),
			.full     (full[c]),
			.empty    (empty[c])
		);

		always_ff @(posedge clk)
		begin
			if (reset || flushAll)
			begin
				popPend_q[c]   <= 1'b0;
				holdValid_q[c] <= 1'b0;
				hold_q[c]      <= '0;
			end
			else
			begin
				popPend_q[c] <= pop[c];
				if (popPend_q[c])
				begin
					holdValid_q[c] <= 1'b1;
					hold_q[c]      <= popData[c];
				end
				else if (consume[c])
					holdValid_q[c] <= 1'b0;
			end
		end

		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				half_q[c]     <= 1'b1;
				room_q[c]     <= 1'b1;
				drained_q[c]  <= 1'b0;
				eotSeen_q[c]  <= 1'b0;
				dmaReady_q[c] <= 1'b0;
			end
			else
			begin
				half_q[c] <= count[c] <= HALF_C;
				room_q[c] <= !full[c];
				if (flushAll || (state_q == audio_tx_pkg::ST_IDLE && enableSync_q))
					eotSeen_q[c] <= 1'b0;
				else if (cfg_q.dma && dmaSrc[c].eot)
					eotSeen_q[c] <= 1'b1;
				drained_q[c] <= started_q && empty[c] && !holdValid_q[c] && !popPend_q[c]
					&& (cfg_q.dma ? eotSeen_q[c] && (!run || curZero_q)
					: !enableSync_q && !run);
				dmaReady_q[c] <= cfg_q.dma && !flushAll
					&& (count[c] + CW'(push[c])) < DEPTH_C;
			end
		end
	end

	// Serial engine: bit clock divided from clk, data and WS change on its falling edge
	assign run        = (state_q == audio_tx_pkg::ST_RUN);
	assign sampleBits = widthBits(cfg_q.width);
	assign slotBits   = (cfg_q.fixedRatio || cfg_q.width == audio_tx_pkg::WIDTH_18
		|| cfg_q.width == audio_tx_pkg::WIDTH_24 || cfg_q.width == audio_tx_pkg::WIDTH_32)
		? audio_tx_pkg::BITS_32 : sampleBits;
	assign fall       = run && sck && halfCnt_q == HALF_LAST;
	assign posNext    = (7'(pos_q) == (slotBits << 1) - 7'h01) ? 6'h00 : pos_q + 6'h01;
	assign frameStart = fall && posNext == 6'h00;
	assign wsPos      = (cfg_q.format == audio_tx_pkg::FMT_I2S
		|| cfg_q.format == audio_tx_pkg::FMT_I2S_ALT)
		? ((7'(posNext) == (slotBits << 1) - 7'h01) ? 6'h00 : posNext + 6'h01) : posNext;
	assign zeroN = frameStart ? (cfg_q.hold || !ready || cfg_q.mute) : curZero_q;
	assign selL  = frameStart ? hold_q[0] : cur_q[0];
	assign selR  = frameStart ? (cfg_q.mono ? hold_q[0] : hold_q[1]) : cur_q[1];
	assign sIdx  = (7'(posNext) >= slotBits) ? 7'(posNext) - slotBits : 7'(posNext);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q   <= audio_tx_pkg::ST_IDLE;
			halfCnt_q <= '0;
			pos_q     <= '0;
			sck       <= 1'b0;
			sd        <= 1'b0;
			ws        <= 1'b0;
			started_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				audio_tx_pkg::ST_IDLE:
				begin
					sck       <= 1'b0;
					halfCnt_q <= '0;
					sd        <= 1'b0;
					if (enableSync_q)
					begin
						state_q   <= audio_tx_pkg::ST_RUN;
						pos_q     <= 6'((slotBits << 1) - 7'h01);
						started_q <= 1'b1;
					end
				end
				audio_tx_pkg::ST_RUN:
				begin
					halfCnt_q <= (halfCnt_q == HALF_LAST) ? '0 : halfCnt_q + 1'b1;
					if (halfCnt_q == HALF_LAST)
						sck <= !sck;
					if (stopEvt)
					begin
						state_q <= audio_tx_pkg::ST_IDLE;
						sd      <= 1'b0;
					end
					else if (fall)
					begin
						pos_q <= posNext;
						sd    <= !zeroN && bitAt((7'(posNext) >= slotBits) ? selR : selL,
							sIdx, slotBits, sampleBits,
							cfg_q.format == audio_tx_pkg::FMT_RIGHT, cfg_q.bitOrderSel);
						ws    <= ((7'(wsPos) >= slotBits) ^ ((cfg_q.format ==
							audio_tx_pkg::FMT_I2S || cfg_q.format == audio_tx_pkg::FMT_I2S_ALT)
							== cfg_q.wordSelectPolarity));
					end
				end
			endcase
		end
	end

	// A hold keeps the fetched pair in place, so output resumes on the same sample
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cur_q[0]    <= '0;
			cur_q[1]    <= '0;
			curZero_q   <= 1'b1;
			pausedEff_q <= 1'b0;
			noData_q    <= 1'b0;
		end
		else if (!run)
			pausedEff_q <= 1'b0;
		else if (frameStart)
		begin
			curZero_q   <= zeroN;
			pausedEff_q <= cfg_q.hold;
			noData_q    <= cfg_q.dma && !cfg_q.hold && !ready && (!dmaSrc[0].empty
				|| (!cfg_q.mono && !dmaSrc[1].empty));
			if (take)
			begin
				cur_q[0] <= selL;
				cur_q[1] <= selR;
			end
		end
	end

	// Error capture keeps the first cause; a new fault wins over a same-cycle clear
	assign errSet   = (regWr[0] && full[0]) || (regWr[1] && full[1]);
	assign errCause = (regWr[0] && full[0]) ? audio_tx_pkg::ERR_LEFT_FULL
		: audio_tx_pkg::ERR_RIGHT_FULL;
	assign errClr   = doWrite && awAddr_q == audio_tx_pkg::STATUS_ADDR
		&& wData_q[audio_tx_pkg::EVT_ERROR] && wMask_q[audio_tx_pkg::EVT_ERROR];
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			error_q   <= 1'b0;
			errCode_q <= audio_tx_pkg::ERR_RESET;
		end
		else
		begin
			error_q <= errSet || (error_q && !errClr);
			if (errSet && (!error_q || errClr))
				errCode_q <= errCause;
		end
	end

	assign status = {error_q, noData_q, pausedEff_q, half_q[1], room_q[1], drained_q[1],
		half_q[0], room_q[0], drained_q[0]};
	assign rise   = status & ~statusPrev_q;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			statusPrev_q <= status;
			irqPend_q    <= '0;
			irq          <= 1'b0;
		end
		else
		begin
			statusPrev_q <= status;
			irqPend_q    <= rise | (irqPend_q & ~((doWrite && awAddr_q ==
				audio_tx_pkg::PENDING_ADDR) ? wData_q[EVT_W_L-1:0]
				& wMask_q[EVT_W_L-1:0] : '0));
			irq          <= |(irqPend_q & irqEn_q);
		end
	end

	enable_stop_a: assert property (@(posedge clk) disable iff (reset)
		(run && !enableSync_q) |-> ##[0:1000] (!run || enableSync_q))
		else $error("engine kept running after enable cleared");
	flush_empty_a: assert property (@(posedge clk) disable iff (reset)
		flushActive |=> (empty == 2'h3) && (holdValid_q == 2'h0))
		else $error("flush did not empty the channels");
	mono_copy_a: assert property (@(posedge clk) disable iff (reset)
		(take && cfg_q.mono) |=> (cur_q[1] == cur_q[0]))
		else $error("mono frame differs between slots");
	mute_zero_a: assert property (@(posedge clk) disable iff (reset)
		(fall && !frameStart && curZero_q) |=> !sd)
		else $error("nonzero data in a silent frame");
	hold_frame_a: assert property (@(posedge clk) disable iff (reset)
		(frameStart && enableSync_q && cfg_q.hold && !flushAll) |=> (curZero_q && pausedEff_q
		&& (holdValid_q[0] || !$past(holdValid_q[0]))))
		else $error("hold frame consumed or sent data");
	err_code_a: assert property (@(posedge clk) disable iff (reset)
		(error_q && !errClr) |=> (error_q && errCode_q == $past(errCode_q)))
		else $error("error flag or cause changed while set");
	overflow_err_a: assert property (@(posedge clk) disable iff (reset)
		((regWr[0] && full[0]) || (regWr[1] && full[1])) |=> error_q)
		else $error("write to full FIFO did not flag error");
	irq_rise_a: assert property (@(posedge clk) disable iff (reset)
		(rise != '0) |=> ((irqPend_q & $past(rise)) == $past(rise)))
		else $error("status rising edge not latched");
	irq_out_a: assert property (@(posedge clk) disable iff (reset)
		(|(irqPend_q & irqEn_q)) |=> irq)
		else $error("enabled request did not raise irq");
endmodule : stereo_audio_serial_transmitter

// [verification/codec_model.sv]
// Serial receiver model that collects one word per word-select slot
`timescale 1ns/1ps
module codec_model (
	input  wire logic       sck,
	input  wire logic       ws,
	input  wire logic       sd,
	output logic     [31:0] word,
	output logic            wsLvl,
	output logic     [6:0]  len,
	output int              slots
);
	logic [31:0] shiftQ;
	logic [6:0]  countQ;
	logic        wsQ;
	initial
	begin
		{shiftQ, countQ, wsQ, word, wsLvl, len} = '0;
		slots = 0;
	end
	// Data is taken on the rising edge, since the sender moves it on the falling one
	always @(posedge sck)
	begin
		if (ws !== wsQ)
		begin
			word <= shiftQ;
			len <= countQ;
			wsLvl <= wsQ;
			slots <= slots + 1;
			shiftQ <= {31'h0, sd};
			countQ <= 7'h01;
			wsQ <= ws;
		end
		else
		begin
			shiftQ <= {shiftQ[30:0], sd};
			countQ <= countQ + 7'h01;
		end
	end
endmodule : codec_model

// [verification/stereo_audio_serial_transmitter_bench.sv]
// Self-checking bench for the stereo audio transmitter
`timescale 1ns/1ps
module stereo_audio_serial_transmitter_bench;
	logic        clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, descModified, leftDmaReady, rightDmaReady, sck, ws, sd, irq;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, v, word;
	logic [31:0] smp[4];
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [6:0]  len;
	logic        wsLvl;
	int          slots, n_mismatch, checks, i;
	audio_tx_pkg::dma_src_t leftDma, rightDma;
	stereo_audio_serial_transmitter #(.FIFO_DEPTH(4), .SCK_HALF(4))
		stereo_audio_serial_transmitter_i (.*);
	codec_model codec_model_i (.sck(sck), .ws(ws), .sd(sd), .word(word), .wsLvl(wsLvl),
		.len(len), .slots(slots));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Address and data are offered together; each drops once taken
	task wr(input logic [31:0] a, input logic [31:0] dat);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end
	initial
	begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		leftDma = '0;
		rightDma = '0;
		descModified = 1'b0;
		seed = 32'h08d24a3f;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(audio_tx_pkg::CONFIG_ADDR);
		chk(v, audio_tx_pkg::CONFIG_RESET);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk(v, 32'h0f000036);
		rd(audio_tx_pkg::LEFT_ADDR);
		chk(v, 32'h0);
		rd(32'he0000020);
		chk({30'h0, rsp}, {30'h0, audio_tx_pkg::AXI_SLVERR});
		$display("reset test done");
		// Overfill left first so the right overflow must not replace the cause
		// One sample sits in the holding register, so depth plus two writes overflow
		for (i = 0; i < 6; i++) wr(audio_tx_pkg::LEFT_ADDR, lfsr(seed));
		for (i = 0; i < 6; i++) wr(audio_tx_pkg::RIGHT_ADDR, 32'h0);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk(v & 32'h0f000112, 32'h01000100);
		chk({31'h0, irq}, 32'h0);
		rd(audio_tx_pkg::PENDING_ADDR);
		chk(v & 32'h100, 32'h100);
		wr(audio_tx_pkg::ENABLE_ADDR, 32'h100);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(audio_tx_pkg::STATUS_ADDR, 32'h100);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk(v & 32'h100, 32'h0);
		wr(audio_tx_pkg::PENDING_ADDR, 32'h100);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h40000102);
		wr(audio_tx_pkg::CONFIG_ADDR, audio_tx_pkg::CONFIG_RESET);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk(v & 32'h12, 32'h12);
		$display("error test done");
		// Left-justified, 16 bits, stereo, unmuted; enable goes in a write of its own
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h00000900);
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			smp[i] = seed;
			wr(i[0] ? audio_tx_pkg::RIGHT_ADDR : audio_tx_pkg::LEFT_ADDR, seed);
		end
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h80000900);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk({31'h0, v[28]}, 32'h1);
		@(slots);
		for (i = 0; i < 4; i++)
		begin
			@(slots);
			chk({16'h0, word[15:0]}, {16'h0, smp[i][15:0]});
			chk({24'h0, wsLvl, len}, {24'h0, ~i[0], 7'h10});
		end
		$display("stream test done");
		// Stop, let the frame finish, then restart in mono after flushing a stale sample
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h00000900);
		do
			rd(audio_tx_pkg::STATUS_ADDR);
		while (v[28]);
		rd(audio_tx_pkg::STATUS_ADDR);
		chk(v & 32'h9, 32'h9);
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h00000920);
		wr(audio_tx_pkg::LEFT_ADDR, 32'h0000ffff);
		descModified <= 1'b1;
		@(posedge clk);
		descModified <= 1'b0;
		seed = lfsr(seed);
		wr(audio_tx_pkg::LEFT_ADDR, seed);
		wr(audio_tx_pkg::CONFIG_ADDR, 32'h80000920);
		@(slots);
		for (i = 0; i < 2; i++)
		begin
			@(slots);
			chk({16'h0, word[15:0]}, {16'h0, seed[15:0]});
			chk({31'h0, wsLvl}, {31'h0, ~i[0]});
		end
		$display("mono test done");
		results();
	end
endmodule : stereo_audio_serial_transmitter_bench
